// [hw/pgls_cfg.svh]
`ifndef PGLS_CFG_SVH
`define PGLS_CFG_SVH
// Channel counts
`define PGLS_NUM_CH        9
`define PGLS_NUM_SHAPE     6
`define PGLS_NUM_FLK       3
// Phase period in clocks, as 12 slots (30 degrees each)
`define PGLS_SLOT_W        8
`define PGLS_SLOT_CYC_DEF  8'h04
`define PGLS_SLOTS         4'hc
// Flicker fall offset inside a phase high time, in slots (start of last 60 / last 90 degrees)
`define PGLS_FLK6_SLOT     4'h4
`define PGLS_FLK4_SLOT     4'h3
// Phase high length in slots: six-phase 180 deg, four-phase 180 deg
`define PGLS_HIGH6_SLOTS   4'h6
`define PGLS_HIGH4_SLOTS   4'h6
// Phase step in slots: six-phase 60 deg, four-phase 90 deg
`define PGLS_STEP6         4'h2
`define PGLS_STEP4         4'h3
`endif

// [hw/pgls_pkg.sv]
package pgls_pkg;
  typedef enum logic [1:0] {
    PGLS_MODE_SIX_ONE,
    PGLS_MODE_SIX_THREE,
    PGLS_MODE_FOUR_TWO
  } pgls_mode_t;
  typedef enum logic [1:0] {
    PGLS_ST_OFF,
    PGLS_ST_RUN
  } pgls_state_t;
endpackage : pgls_pkg

// [hw/pgls_phase_gen.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pgls_cfg.svh"
module pgls_phase_gen
  import pgls_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic [7:0]  slot_cyc_i,
  output logic      [3:0]  slot_o,
  output logic             slot_tick_o
);
  logic [7:0] cyc_q;
  logic [3:0] slot_q;
  wire        tick_w = (cyc_q >= slot_cyc_i - 8'h01);
  assign slot_o      = slot_q;
  assign slot_tick_o = tick_w & run_i;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !run_i)
    begin
      cyc_q  <= 8'h00;
      slot_q <= 4'h0;
    end
    else if (tick_w)
    begin
      cyc_q  <= 8'h00;
      slot_q <= (slot_q == `PGLS_SLOTS - 4'h1) ? 4'h0 : slot_q + 4'h1;
    end
    else
      cyc_q <= cyc_q + 8'h01;
  end
endmodule : pgls_phase_gen
`default_nettype wire

// [hw/pgls_host.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pgls_cfg.svh"
// Summary of operation
// - Six-phase single flicker: drive flicker a, hold b and c low.
// - Six-phase triple flicker: a for 1/4, b for 2/5, c for 3/6.
// - Four-phase: a for phases 1/3, b for 2/4, c low.
// - Four-phase: inputs three and six held high.
// - Host places every shaping flicker fall inside its governed phase window.
module pgls_host
  import pgls_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        enable_i,
  input  wire pgls_mode_t  mode_i,
  input  wire logic [7:0]  slot_cyc_i,
  input  wire logic [2:0]  static_in_i,
  input  wire logic        fault_uv_i,
  input  wire logic        fault_ot_i,
  output logic      [8:0]  channel_input_o,
  output logic             flicker_in_a_o,
  output logic             flicker_in_b_o,
  output logic             flicker_in_c_o,
  output logic             running_o
);
  pgls_state_t state_q;
  pgls_state_t state_d;
  logic [2:0]  phase_q;
  logic [8:0]  chan_q;
  logic [2:0]  flk_q;
  logic        run_q;
  logic [3:0]  slot_w;
  logic        tick_w;
  wire         fault_w  = fault_uv_i | fault_ot_i;
  wire         four_w   = (mode_i == PGLS_MODE_FOUR_TWO);
  wire  [3:0]  step_w   = four_w ? `PGLS_STEP4 : `PGLS_STEP6;
  wire  [3:0]  high_w   = four_w ? `PGLS_HIGH4_SLOTS : `PGLS_HIGH6_SLOTS;
  wire  [3:0]  flkpos_w = four_w ? `PGLS_FLK4_SLOT : `PGLS_FLK6_SLOT;

  // Slot position s relative to the start of the phase at offset off, modulo 12
  function automatic logic [3:0] rel_slot(input logic [3:0] s, input logic [3:0] off);
    logic [4:0] t;
    t = {1'b0, s} + 5'd12 - {1'b0, off};
    rel_slot = (t >= 5'd12) ? t[3:0] - `PGLS_SLOTS : t[3:0];
  endfunction : rel_slot

  pgls_phase_gen u_gen (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .run_i       (run_q),
    .slot_cyc_i  (slot_cyc_i),
    .slot_o      (slot_w),
    .slot_tick_o (tick_w)
  );

  // Phase levels: each shaped phase high for high_w slots, stepped in order
  logic [5:0] ph_lvl_w;
  logic [5:0] ph_fall_w;
  genvar g;
  generate
    for (g = 0; g < `PGLS_NUM_SHAPE; g++)
    begin : g_ph
      wire [3:0] off_w = four_w ? 4'((g % 4) * 3) : 4'(g * 2);
      wire [3:0] rs_w  = rel_slot(slot_w, off_w);
      assign ph_lvl_w[g]  = run_q && (rs_w < high_w);
      assign ph_fall_w[g] = run_q && (rs_w == flkpos_w);
    end
  endgenerate

  // Channel inputs: four-phase maps phases 1,2,4,5 and holds 3,6 high
  logic [8:0] chan_d;
  assign chan_d[0] = ph_lvl_w[0];
  assign chan_d[1] = ph_lvl_w[1];
  assign chan_d[2] = four_w ? run_q : ph_lvl_w[2];
  assign chan_d[3] = four_w ? ph_lvl_w[2] : ph_lvl_w[3];
  assign chan_d[4] = four_w ? ph_lvl_w[3] : ph_lvl_w[4];
  assign chan_d[5] = four_w ? run_q : ph_lvl_w[5];
  assign chan_d[8:6] = run_q ? static_in_i : 3'h0;

  // Flicker: low for the one slot at each fall position, high otherwise while running, low when stopped or unused; only falls matter
  logic [2:0] flk_d;
  wire  any_fall_w = |ph_fall_w;
  always_comb
  begin
    flk_d = 3'h0;
    if (run_q)
    begin
      unique case (mode_i)
        PGLS_MODE_SIX_ONE:
          flk_d = {2'b00, ~any_fall_w};
        PGLS_MODE_SIX_THREE:
          flk_d = ~{ph_fall_w[2] | ph_fall_w[5], ph_fall_w[1] | ph_fall_w[4],
                    ph_fall_w[0] | ph_fall_w[3]};
        PGLS_MODE_FOUR_TWO:
          flk_d = {1'b0, ~(ph_fall_w[1] | ph_fall_w[3]),
                   ~(ph_fall_w[0] | ph_fall_w[2])};
        default:
          flk_d = 3'h0;
      endcase
    end
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PGLS_ST_OFF: if (enable_i && !fault_w) state_d = PGLS_ST_RUN;
      PGLS_ST_RUN: if (!enable_i || fault_w) state_d = PGLS_ST_OFF;
      default:     state_d = PGLS_ST_OFF;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_q <= PGLS_ST_OFF;
      run_q   <= 1'b0;
      chan_q  <= 9'h000;
      flk_q   <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      run_q   <= (state_d == PGLS_ST_RUN);
      chan_q  <= chan_d;
      flk_q   <= flk_d;
    end
  end

  assign channel_input_o = chan_q;
  assign flicker_in_a_o  = flk_q[0];
  assign flicker_in_b_o  = flk_q[1];
  assign flicker_in_c_o  = flk_q[2];
  assign running_o       = run_q;
endmodule : pgls_host
`default_nettype wire

// [tb/pgls_host_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module pgls_host_sva
  import pgls_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire pgls_mode_t mode_i,
  input wire logic       enable_i,
  input wire logic       fault_uv_i,
  input wire logic       fault_ot_i,
  input wire logic [8:0] channel_input_o,
  input wire logic       flicker_in_a_o,
  input wire logic       flicker_in_b_o,
  input wire logic       flicker_in_c_o,
  input wire logic       running_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire [5:0] c = channel_input_o[5:0];
  wire six3 = mode_i == PGLS_MODE_SIX_THREE;
  wire four = mode_i == PGLS_MODE_FOUR_TWO;
  AST_UV: assert property (fault_uv_i |-> ##[1:2] (channel_input_o == 9'h000 && !running_o))
    else $error("outputs not idle in undervoltage");
  AST_OT: assert property (fault_ot_i |-> ##[1:2] (channel_input_o == 9'h000 && !running_o))
    else $error("outputs not idle in overtemperature");
  AST_RUN: assert property (enable_i && !fault_uv_i && !fault_ot_i |=> running_o)
    else $error("run not started");
  AST_ONE: assert property (mode_i == PGLS_MODE_SIX_ONE |-> !flicker_in_b_o && !flicker_in_c_o)
    else $error("unused flicker driven");
  AST_FOUR_C: assert property (four |-> !flicker_in_c_o)
    else $error("third flicker driven");
  AST_HOLD: assert property (four && running_o && $past(running_o) |-> c[2] && c[5])
    else $error("unused phases not high");
  AST_WIN_A: assert property (six3 && running_o && $fell(flicker_in_a_o) |-> (&c[2:0]) || (&c[5:3]))
    else $error("flicker a fall out of window");
  AST_WIN_B: assert property (six3 && running_o && $fell(flicker_in_b_o) |-> (&c[3:1]) || (&{c[5:4], c[0]}))
    else $error("flicker b fall out of window");
  AST_WIN_C: assert property (six3 && running_o && $fell(flicker_in_c_o) |-> (&c[4:2]) || (&{c[5], c[1:0]}))
    else $error("flicker c fall out of window");
  AST_WIN_4: assert property (four && running_o && $fell(flicker_in_a_o) |-> (&c[1:0]) || (&c[4:3]))
    else $error("four phase fall out of window");
  AST_WIN_4B: assert property (four && running_o && $fell(flicker_in_b_o) |-> (c[1] && c[3]) || (c[4] && c[0]))
    else $error("four phase b fall out of window");
endmodule : pgls_host_sva
bind pgls_host pgls_host_sva u_sva (.*);
`default_nettype wire

// [tb/pgls_dev_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pgls_dev_model
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        inhibit_i,
  input  wire logic        one_i,
  input  wire logic [8:0]  ch_in_i,
  input  wire logic [2:0]  flk_i,
  output logic      [8:0]  gate_hi_o,
  output logic      [15:0] n_acc_o,
  output logic      [15:0] n_bad_o
);
  logic [5:0] decay_q;
  logic [2:0] flk_q;
  logic [5:0] in_q;
  wire  [5:0] c = ch_in_i[5:0];
  wire  [5:0] win = c & {c[0], c[5:1]} & {c[1:0], c[5:2]};
  wire  [2:0] fell = flk_q & ~flk_i;
  wire  [5:0] hit = (one_i ? {6{fell[0]}} : {2{fell}}) & win;
  assign gate_hi_o = inhibit_i ? 9'h000 : ch_in_i & ~{3'h0, decay_q};
  always_ff @(posedge mclk_i)
  begin
    flk_q <= flk_i;
    in_q <= c;
    if (rst_i)
    begin
      decay_q <= '0;
      n_acc_o <= '0;
      n_bad_o <= '0;
    end
    else
    begin
      decay_q <= (decay_q | hit) & ~(in_q ^ c);
      n_acc_o <= n_acc_o + {15'h0, |hit};
      n_bad_o <= n_bad_o + {15'h0, (|fell) && !(|hit) && !inhibit_i};
    end
  end
endmodule : pgls_dev_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pgls_pkg::*;
  logic mclk_i = 0, rst_i = 1, en = 0, fuv = 0, fot = 0, fa, fb, fc, run;
  pgls_mode_t mode = PGLS_MODE_SIX_THREE;
  logic [2:0] stat = 3'h5;
  logic [8:0] ch;
  wire [8:0] gh;
  wire [15:0] n_acc, n_bad;
  int n_errors = 0, tests_run = 0, cyc = 0;
  pgls_host u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .enable_i(en), .mode_i(mode), .slot_cyc_i(8'h04),
    .static_in_i(stat), .fault_uv_i(fuv), .fault_ot_i(fot), .channel_input_o(ch), .flicker_in_a_o(fa),
    .flicker_in_b_o(fb), .flicker_in_c_o(fc), .running_o(run));
  pgls_dev_model u_dev (.mclk_i(mclk_i), .rst_i(rst_i), .inhibit_i(fuv | fot), .one_i(mode == PGLS_MODE_SIX_ONE),
    .ch_in_i(ch), .flk_i({fc, fb, fa}), .gate_hi_o(gh), .n_acc_o(n_acc), .n_bad_o(n_bad));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic start(input pgls_mode_t m);
    @(negedge mclk_i) rst_i = 1;
    en = 0;
    mode = m;
    repeat (16) @(negedge mclk_i);
    rst_i = 0;
    en = 1;
    repeat (300) @(negedge mclk_i);
    chk("running", run, 1);
    chk("bad falls", n_bad, 0);
    chk("shaped", n_acc != 0, 1);
    chk("static", ch[8:6], stat);
    chk("gate static", gh[8:6], stat);
  endtask : start
  task automatic t_four();
    start(PGLS_MODE_FOUR_TWO);
    chk("hold", {ch[5], ch[2], fc}, 3'h6);
  endtask : t_four
  task automatic t_fault();
    start(PGLS_MODE_SIX_ONE);
    chk("one", {fb, fc}, 0);
    fot = 1;
    repeat (2) @(negedge mclk_i);
    chk("ot run", run, 0);
    chk("ot", {ch, gh}, 0);
    fot = 0;
    stat = 3'h2;
    repeat (100) @(negedge mclk_i);
    chk("resume", {run, ch[8:6]}, 4'ha);
    fuv = 1;
    repeat (2) @(negedge mclk_i);
    chk("uv", {run, ch}, 0);
    fuv = 0;
  endtask : t_fault
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  initial
  begin
    start(PGLS_MODE_SIX_THREE);
    t_four();
    t_fault();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
